// >>> src/kwu_consts.vh
// Constants for the key-on wakeup unit: register map, field positions and reset values.
// Assumes inclusion by kwu_key_wakeup.v only.
`ifndef KWU_CONSTS_VH
`define KWU_CONSTS_VH
`define KWU_ENABLE_OFFSET 32'h0000_0031
`define KWU_ENABLE_ADDR 32'h0000_00C4
`define KWU_STATUS_ADDR 32'h0000_0100
`define KWU_CTRL_ADDR 32'h0000_0104
`define KWU_EN_LSB 4
`define KWU_EN_MSB 7
`define KWU_EN_RESET 4'h0
`define KWU_CTRL_RESET 2'h0
`define KWU_CTRL_LEVEL_BIT 0
`define KWU_CTRL_ENTRY_BIT 1
`define KWU_PIN_PRIMARY 4
`define KWU_PIN_COUNT 5
`define KWU_PIN_IDLE 5'h0F
`endif

// >>> src/kwu_key_wakeup.v
// Key-on wakeup unit: four low-level key inputs plus the primary release pin end STOP mode.
// Assumes an AHB-Lite master on ref_clk and pins that are already configured as inputs.
// Key release detection is clock-free; the bus side sees synchronised copies of the pins.
// Overview of operation
// - Four key inputs can end STOP mode.
// - One enable bit per key input.
// - Enable register bits 7..4, write-only, at 0x31.
// - Enables reset to zero; low nibble undefined.
// - Enabled key low starts release in STOP, in level mode only.
// - Release condition at STOP entry skips stopping.
// - Primary pin: high level or rising edge.
// - Primary pin always acts as release source.
`timescale 1ns/1ps
`include "kwu_consts.vh"
module kwu_key_wakeup (
   input wire ref_clk,
   input wire resetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   input wire key_wake_input_a,
   input wire key_wake_input_b,
   input wire key_wake_input_c,
   input wire key_wake_input_d,
   input wire stop_pin,
   input wire stop_mode,
   output wire release_async,
   output reg release_req
);
   // Enable bit 3 serves key d and bit 0 serves key a.
   reg [3:0] key_wake_enable_reg;
   reg [1:0] ctrl_reg;
   reg wr_pend_reg;
   reg [31:0] wr_addr_reg;
   reg [4:0] pin_meta_reg;
   reg [4:0] pin_sync_reg;
   reg stop_prev_reg;
   reg edge_flag_reg;
   wire [4:0] pin_raw;
   wire release_mode_level;
   wire stop_enter_cmd;
   wire [3:0] keys_raw;
   wire key_low_raw;
   wire primary_raw;
   wire [3:0] keys_sync;
   wire primary_high_sync;
   wire key_low_sync;
   wire primary_level_sync;
   wire primary_rise_sync;
   wire release_cond_sync;
   wire stop_or_entry;
   wire entry_pin_high;
   wire addr_phase;
   wire rd_phase;
   wire wr_enable_hit;
   wire wr_ctrl_hit;
   wire rd_status_hit;
   wire rd_ctrl_hit;
   genvar pin_idx;

   // Key pins rest high behind their pull-ups and the primary pin rests low, so the
   // synchroniser resets to the idle levels and no false press or edge follows reset.
   localparam [4:0] PIN_IDLE = `KWU_PIN_IDLE;

   // True when any enabled key is held low. One decode serves the clock-free path
   // and the synchronised path, so the two can never disagree about which keys count.
   function key_any_low;
      input [3:0] enables;
      input [3:0] levels;
      begin
         key_any_low = |(enables & ~levels);
      end
   endfunction

   // Full-word compare of a bus address against one register's byte address.
   function addr_hit;
      input [31:0] addr;
      input [31:0] target;
      begin
         addr_hit = (addr == target);
      end
   endfunction

   // Zero-wait slave with an OKAY response; hsize is not decoded, as only words exist.
   // Decodes are full 32-bit compares, so the registers have no aliases.
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign addr_phase = hsel & htrans[1] & hready;
   assign rd_phase = addr_phase & ~hwrite;
   assign wr_enable_hit = wr_pend_reg & addr_hit(wr_addr_reg, `KWU_ENABLE_ADDR);
   assign wr_ctrl_hit = wr_pend_reg & addr_hit(wr_addr_reg, `KWU_CTRL_ADDR);
   assign rd_status_hit = addr_hit(haddr, `KWU_STATUS_ADDR);
   assign rd_ctrl_hit = addr_hit(haddr, `KWU_CTRL_ADDR);

   // Bit 0 selects the release mode (1 = level), bit 1 is a STOP request seen by this unit.
   assign release_mode_level = ctrl_reg[`KWU_CTRL_LEVEL_BIT];
   assign stop_enter_cmd = ctrl_reg[`KWU_CTRL_ENTRY_BIT];

   // The address phase is remembered so that the write lands with hwdata one edge later.
   always @(posedge ref_clk) begin
      if (!resetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 32'h0000_0000;
      end else begin
         wr_pend_reg <= addr_phase & hwrite;
         if (addr_phase) begin
            wr_addr_reg <= haddr;
         end
      end
   end

   // Only bits 7 to 4 of the written word are kept; the low nibble has no storage.
   always @(posedge ref_clk) begin
      if (!resetn) begin
         key_wake_enable_reg <= `KWU_EN_RESET;
      end else if (wr_enable_hit) begin
         key_wake_enable_reg <= hwdata[`KWU_EN_MSB:`KWU_EN_LSB];
      end
   end

   // The entry bit is a one-cycle pulse. A write that sets it wins over the self-clear,
   // so a STOP request written on consecutive transfers is never lost.
   always @(posedge ref_clk) begin
      if (!resetn) begin
         ctrl_reg <= `KWU_CTRL_RESET;
      end else if (wr_ctrl_hit) begin
         ctrl_reg <= hwdata[1:0];
      end else begin
         ctrl_reg[`KWU_CTRL_ENTRY_BIT] <= 1'b0;
      end
   end

   // The enable register is write-only and reads as zero, as do unmapped addresses.
   // Status shows the synchronised pins so software can compare them with the ports.
   // Reads are decoded in the address phase, so hrdata stands for the whole data phase.
   always @(posedge ref_clk) begin
      if (!resetn) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_phase) begin
         if (rd_status_hit) begin
            hrdata <= {25'h0000000, stop_prev_reg, edge_flag_reg, pin_sync_reg};
         end else if (rd_ctrl_hit) begin
            hrdata <= {31'h0000_0000, ctrl_reg[`KWU_CTRL_LEVEL_BIT]};
         end else begin
            hrdata <= 32'h0000_0000;
         end
      end
   end

   // Key d sits in the top bit, matching enable bit 7.
   assign keys_raw = {key_wake_input_d, key_wake_input_c, key_wake_input_b, key_wake_input_a};
   assign pin_raw = {stop_pin, keys_raw};

   // Ungated by the clock so a stopped oscillator can still be restarted.
   assign key_low_raw = release_mode_level &
                        key_any_low(key_wake_enable_reg, keys_raw);
   assign primary_raw = stop_pin & release_mode_level;
   // Edge mode needs a clock-free latch outside; only the level path is asynchronous here.
   assign release_async = stop_mode & (key_low_raw | primary_raw);

   // Two flip-flops per pin; nothing but the second stage reads the first.
   generate
      for (pin_idx = 0; pin_idx < `KWU_PIN_COUNT; pin_idx = pin_idx + 1) begin : g_pin_sync
         always @(posedge ref_clk) begin
            if (!resetn) begin
               pin_meta_reg[pin_idx] <= PIN_IDLE[pin_idx];
               pin_sync_reg[pin_idx] <= PIN_IDLE[pin_idx];
            end else begin
               pin_meta_reg[pin_idx] <= pin_raw[pin_idx];
               pin_sync_reg[pin_idx] <= pin_meta_reg[pin_idx];
            end
         end
      end
   endgenerate

   // The previous sample of the primary pin gives the rising edge for edge mode.
   always @(posedge ref_clk) begin
      if (!resetn) begin
         stop_prev_reg <= 1'b0;
         edge_flag_reg <= 1'b0;
      end else begin
         stop_prev_reg <= primary_high_sync;
         edge_flag_reg <= primary_rise_sync;
      end
   end

   // Synchronised copies of the same decodes drive the registered request.
   assign keys_sync = pin_sync_reg[3:0];
   assign primary_high_sync = pin_sync_reg[`KWU_PIN_PRIMARY];
   assign key_low_sync = release_mode_level &
                         key_any_low(key_wake_enable_reg, keys_sync);
   assign primary_level_sync = release_mode_level & primary_high_sync;
   assign primary_rise_sync = ~release_mode_level & primary_high_sync & ~stop_prev_reg;
   assign release_cond_sync = key_low_sync | primary_level_sync | primary_rise_sync;
   assign stop_or_entry = stop_mode | stop_enter_cmd;
   // At the STOP command a high primary pin releases in either mode.
   assign entry_pin_high = stop_enter_cmd & primary_high_sync;

   // A pending release at the STOP command goes straight to warm-up instead of stopping.
   // The request lags the pins by the two synchroniser stages plus this register.
   always @(posedge ref_clk) begin
      if (!resetn) begin
         release_req <= 1'b0;
      end else begin
         release_req <= (stop_or_entry & release_cond_sync) | entry_pin_high;
      end
   end
endmodule

// >>> tb/kwu_keys.sv
// Key and release switch model.
// Assumes the bench drives press and pin_on.
`timescale 1ns/1ps
module kwu_keys (
   input wire [3:0] press,
   input wire pin_on,
   output wire key_wake_input_a, key_wake_input_b, key_wake_input_c, key_wake_input_d,
   output wire stop_pin
);
   // Pull-ups hold idle keys high, so only a press reads low.
   assign {key_wake_input_d, key_wake_input_c, key_wake_input_b, key_wake_input_a} = ~press;
   // Both drive digital levels into pins set as inputs, never analog ones.
   // Rests low, so keys alone can wake.
   assign stop_pin = pin_on;
endmodule

// >>> tb/kwu_chk.sv
// Port checker for the wakeup unit.
// Assumes a bind into kwu_key_wakeup.
`timescale 1ns/1ps
module kwu_chk (
   input wire ref_clk, resetn, hwrite, hreadyout, hresp, stop_mode, stop_pin,
   input wire key_wake_input_a, key_wake_input_b, key_wake_input_c, key_wake_input_d,
   input wire release_async, release_req,
   input wire [1:0] htrans,
   input wire [31:0] haddr, hrdata
);
   wire rd = htrans[1] && !hwrite;
   wire up = key_wake_input_a & key_wake_input_b & key_wake_input_c & key_wake_input_d;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   a_ready_one: assert property (hreadyout) else $error("wait");
   a_resp_okay: assert property (!hresp) else $error("resp");
   a_reset_zero: assert property ($rose(resetn) |-> !release_req && !hrdata) else $error("rst");
   a_wo_read: assert property (rd && haddr == 32'hC4 |=> !hrdata) else $error("wo");
   a_hold_data: assert property ($changed(hrdata) |-> $past(rd)) else $error("hold");
   a_run_quiet: assert property (!stop_mode |-> !release_async) else $error("run");
   a_keys_up: assert property (stop_mode && up && !stop_pin |-> !release_async) else $error("up");
   a_sync_req: assert property (release_async [*4] |-> release_req) else $error("sync");
   c_async: cover property (release_async);
   c_req: cover property (release_req);
   c_rd: cover property (rd && haddr == 32'h100);
endmodule

// >>> tb/kwu_key_wakeup_tb.sv
// Bench: AHB-Lite master and key model around the wakeup unit.
// Assumes zero-wait answers.
`timescale 1ns/1ps
module kwu_key_wakeup_tb;
   logic ref_clk, resetn, hsel, hwrite, stop_mode, pin_on;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [3:0] press;
   logic [31:0] haddr, hwdata, q;
   wire hreadyout, hresp, release_async, release_req, stop_pin;
   wire key_wake_input_a, key_wake_input_b, key_wake_input_c, key_wake_input_d;
   wire [31:0] hrdata;
   int fail_count = 0, compares = 0, n;
   kwu_keys keys_u (.*);
   kwu_key_wakeup dut_u (.*, .hready(hreadyout));
   task stop_test;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input logic c);
      compares++;
      if (c !== 1'h1) fail_count++;
      if (c !== 1'h1) $display("MISMATCH %0t value", $time);
   endtask
   task rdy;
      n = 0;
      do @(posedge ref_clk); while (hreadyout !== 1'h1 && ++n < 9);
      if (n > 8) chk(1'h0);
      if (n > 8) stop_test;
   endtask
   task xfer(input logic w, input logic [31:0] a, d);
      @(posedge ref_clk);
      {hsel, htrans, hwrite, haddr} <= {3'h6, w, a};
      rdy;
      {hsel, htrans, hwdata} <= {3'h0, d};
      rdy;
      q = hrdata;
   endtask
   // Flags are pin, stop, expected async and expected request, high bit first.
   task set(input logic [3:0] p, f);
      @(posedge ref_clk);
      {press, pin_on, stop_mode} <= {p, f[3:2]};
      @(negedge ref_clk);
      chk(release_async === f[1]);
      // Two sync stages and a register: an edge-mode pulse stands only at the third.
      repeat (3) @(negedge ref_clk);
      chk(release_req === f[0]);
   endtask
   // STOP entry with a release already pending must raise the request within nine clock cycles.
   task entry(input logic [31:0] d);
      xfer(1'h1, 32'h104, d);
      for (n = 0; n < 9 && release_req !== 1'h1; n++) @(negedge ref_clk);
      chk(release_req === 1'h1);
      if (n > 8) stop_test;
   endtask
   task t_level;
      xfer(1'h1, 32'h104, 32'h1);
      set(4'hF, 4'h4);
      xfer(1'h1, 32'hC4, 32'h20);
      set(4'h1, 4'h4);
      set(4'h2, 4'h7);
      set(4'h0, 4'hF);
      set(4'h2, 4'h0);
      entry(32'h3);
      $display("t_level done");
   endtask
   task t_edge;
      xfer(1'h1, 32'h104, 32'h0);
      set(4'h0, 4'h0);
      xfer(1'h0, 32'h100, 32'h0);
      chk(q[4:0] === 5'h0F);
      xfer(1'h0, 32'hC4, 32'h0);
      chk(q === 32'h0);
      xfer(1'h0, 32'h200, 32'h0);
      chk(q === 32'h0);
      set(4'h2, 4'h4);
      set(4'h0, 4'hD);
      set(4'h0, 4'h8);
      entry(32'h2);
      $display("t_edge done");
   endtask
   initial begin
      ref_clk = 1'h0;
      forever #25 ref_clk = ~ref_clk;
   end
   initial begin
      {resetn, hsel, htrans, hwrite, haddr, hwdata} <= 69'h0;
      {hsize, press, pin_on, stop_mode} <= 9'h80;
      repeat (20) @(posedge ref_clk);
      resetn <= 1'h1;
      t_level;
      t_edge;
      stop_test;
   end
endmodule
bind kwu_key_wakeup kwu_chk chk_u (.ref_clk(ref_clk), .resetn(resetn), .hwrite(hwrite),
   .hreadyout(hreadyout), .hresp(hresp), .stop_mode(stop_mode), .stop_pin(stop_pin),
   .key_wake_input_a(key_wake_input_a), .key_wake_input_b(key_wake_input_b),
   .key_wake_input_c(key_wake_input_c), .key_wake_input_d(key_wake_input_d),
   .release_async(release_async), .release_req(release_req), .htrans(htrans),
   .haddr(haddr), .hrdata(hrdata));
